// File: src/isde_pkg.sv
// Shared constants and types for the interrupt split descriptor executor
`default_nettype none
package isde_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;
  localparam logic [7:0]  REG_ROUTE  = 8'h00;
  localparam logic [7:0]  REG_SCHED  = 8'h04;
  localparam logic [7:0]  REG_STATUS = 8'h08;
  localparam logic [7:0]  REG_SLOTS  = 8'h0c;
  localparam logic [7:0]  REG_CSPLIT = 8'h10;
  localparam logic [7:0]  REG_CTRL   = 8'h14;
  localparam logic [31:0] RD_ZERO    = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Field constants
  // ---------------------------------------------------------------
  localparam int unsigned RES_XERR     = 0;
  localparam int unsigned RES_BABBLE   = 1;
  localparam int unsigned RES_UNDERRUN = 2;
  localparam logic [4:0]  EXP_MIN      = 5'h04;
  localparam logic [4:0]  EXP_MAX      = 5'h10;
  localparam logic [1:0]  RETRY_NONE   = 2'h0;
  localparam logic [1:0]  RETRY_STEP   = 2'h1;
  localparam logic [7:0]  UF_ONE       = 8'h01;
  localparam logic [7:0]  MASK_NONE    = 8'h00;
  localparam logic [15:0] FMASK_ONE    = 16'h0001;

  // ---------------------------------------------------------------
  // Register layouts
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [6:0]  hub_addr;
    logic [6:0]  tt_port;
    logic [1:0]  split_position_code;
    logic [15:0] rsvd;
  } isde_route_t;

  typedef struct packed {
    logic [7:0]  rsvd;
    logic [15:0] buffer_base;
    logic [4:0]  frame_sel;
    logic [2:0]  frame_low;
  } isde_sched_t;

  typedef struct packed {
    logic        active;
    logic        halted;
    logic        babble;
    logic        xact_err;
    logic        split_phase;
    logic        rsvd1;
    logic        data_toggle;
    logic [1:0]  retry;
    logic [10:0] rsvd0;
    logic [11:0] bytes_done;
  } isde_status_t;

  typedef struct packed {
    logic [7:0][2:0] slot_result;
    logic [7:0]      start_split_mask;
  } isde_slots_t;

  typedef struct packed {
    logic [23:0] rsvd;
    logic [7:0]  complete_split_mask;
  } isde_csplit_t;

  typedef struct packed {
    logic [24:0] rsvd;
    logic [4:0]  interval_exp;
    logic        is_in;
    logic        valid;
  } isde_ctrl_t;

  // ---------------------------------------------------------------
  // Transaction engine carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        complete;
    logic        is_in;
    logic [2:0]  uframe;
    logic [6:0]  hub_addr;
    logic [6:0]  tt_port;
    logic [1:0]  split_position_code;
    logic        data_toggle;
    logic [15:0] buffer_base;
  } isde_req_t;

  typedef struct packed {
    logic [2:0]  result;
    logic        stall;
    logic        data_phase;
    logic [11:0] bytes;
  } isde_rsp_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } isde_state_t;

endpackage
`default_nettype wire

// File: src/isde_interval.sv
// Polling interval decode: says whether the current frame is a due frame
`default_nettype none
module isde_interval
  import isde_pkg::*;
(
  input  wire logic [4:0]  interval_exp_i,
  input  wire logic [4:0]  frame_sel_i,
  input  wire logic [10:0] frame_num_i,
  output logic             due_o
);
  logic [4:0]  exp_c;
  logic [3:0]  shift;
  logic [15:0] fmask;

  // Out-of-range exponents are clamped rather than trusted
  assign exp_c = (interval_exp_i < EXP_MIN) ? EXP_MIN :
                 (interval_exp_i > EXP_MAX) ? EXP_MAX : interval_exp_i;
  // Period is 2^(b-1) microframes, i.e. 2^(b-4) frames
  assign shift = 4'(exp_c - EXP_MIN);
  assign fmask = 16'((FMASK_ONE << shift) - FMASK_ONE);
  // At the smallest exponent the mask is empty: every frame is due
  assign due_o = ((16'(frame_num_i) ^ 16'(frame_sel_i)) & fmask)
                 == 16'h0000;
endmodule
`default_nettype wire

// File: src/isde_exec.sv
// Interrupt split transfer descriptor: storage, scheduling and write-back
`default_nettype none
module isde_exec
  import isde_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        nrst_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  input  wire logic        uf_start_i,
  input  wire logic [2:0]  uframe_i,
  input  wire logic [10:0] frame_num_i,
  output logic             req_valid_o,
  output isde_req_t        req_o,
  input  wire logic        rsp_valid_i,
  input  wire isde_rsp_t   rsp_i
);

  // ---------------------------------------------------------------
  // Storage and decode
  // ---------------------------------------------------------------
  isde_route_t  route;
  isde_sched_t  sched;
  isde_status_t stat;
  isde_slots_t  slots;
  isde_csplit_t csm;
  isde_ctrl_t   ctrl;
  isde_state_t  state;
  logic [2:0]   cur_uf;
  logic         cur_cs;
  logic         due;

  logic wr_route;
  logic wr_sched;
  logic wr_stat;
  logic wr_slots;
  logic wr_csm;
  logic wr_ctrl;
  assign wr_route = wr_i && (addr_i == REG_ROUTE);
  assign wr_sched = wr_i && (addr_i == REG_SCHED);
  assign wr_stat  = wr_i && (addr_i == REG_STATUS);
  assign wr_slots = wr_i && (addr_i == REG_SLOTS);
  assign wr_csm   = wr_i && (addr_i == REG_CSPLIT);
  assign wr_ctrl  = wr_i && (addr_i == REG_CTRL);

  isde_interval u_interval (
    .interval_exp_i (ctrl.interval_exp),
    .frame_sel_i    (sched.frame_sel),
    .frame_num_i    (frame_num_i),
    .due_o          (due)
  );

  // ---------------------------------------------------------------
  // Scheduling and outcome decode
  // ---------------------------------------------------------------
  logic [7:0] now_bit;
  logic [7:0] cur_bit;
  logic       ss_hit;
  logic       cs_hit;
  logic       issue;
  logic       evt;
  logic       err;
  logic       fatal;
  logic       good;
  logic       good_data;
  logic [7:0] ss_after;
  logic [7:0] cs_after;
  logic       finish;

  assign now_bit = UF_ONE << uframe_i;
  assign cur_bit = UF_ONE << cur_uf;
  // Frame gate holds for complete splits too, so both issue only in due frames
  assign ss_hit  = !stat.split_phase &&
                   ((slots.start_split_mask & now_bit) != MASK_NONE);
  assign cs_hit  = ctrl.is_in && stat.split_phase &&
                   ((csm.complete_split_mask & now_bit) != MASK_NONE);
  assign issue   = (state == ST_IDLE) && uf_start_i && ctrl.valid &&
                   stat.active && due && (ss_hit || cs_hit);

  assign evt       = (state == ST_BUSY) && rsp_valid_i;
  assign err       = rsp_i.result[RES_XERR];
  assign fatal     = rsp_i.stall || (err && (stat.retry == RETRY_NONE));
  assign good      = !err && !rsp_i.stall;
  assign good_data = good && rsp_i.data_phase;
  assign ss_after  = (good && !cur_cs) ?
                     (slots.start_split_mask & ~cur_bit) :
                     slots.start_split_mask;
  assign cs_after  = (good && cur_cs) ?
                     (csm.complete_split_mask & ~cur_bit) :
                     csm.complete_split_mask;
  // OUT has no complete-split list, so only the start list decides
  assign finish    = evt && (fatal || ((ss_after == MASK_NONE) &&
                     (!ctrl.is_in || (cs_after == MASK_NONE))));

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state  <= ST_IDLE;
      cur_uf <= 3'h0;
      cur_cs <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (issue) begin
            state  <= ST_BUSY;
            cur_uf <= uframe_i;
            cur_cs <= !ss_hit;
          end
        end
        ST_BUSY: begin
          if (rsp_valid_i) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Request stays up until the engine answers
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      req_valid_o <= 1'b0;
      req_o       <= '0;
    end else begin
      if (issue) begin
        req_valid_o               <= 1'b1;
        req_o.complete            <= !ss_hit;
        req_o.is_in               <= ctrl.is_in;
        req_o.uframe              <= uframe_i;
        req_o.hub_addr            <= route.hub_addr;
        req_o.tt_port             <= route.tt_port;
        req_o.split_position_code <= route.split_position_code;
        req_o.data_toggle         <= stat.data_toggle;
        req_o.buffer_base         <= sched.buffer_base;
      end else if (evt) begin
        req_valid_o <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Software-only words
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      route <= '0;
      sched <= '0;
    end else begin
      // Reserved bits never keep a written one, so they read back as zero
      if (wr_route) begin
        route      <= isde_route_t'(wdata_i);
        route.rsvd <= '0;
      end
      if (wr_sched) begin
        sched      <= isde_sched_t'(wdata_i);
        sched.rsvd <= '0;
      end
    end
  end

  // Valid: hardware clear loses to a software set in the same cycle
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl <= '0;
    end else begin
      if (finish) ctrl.valid <= 1'b0;
      if (wr_ctrl) begin
        ctrl      <= isde_ctrl_t'(wdata_i);
        ctrl.rsvd <= '0;
      end
    end
  end

  // Masks: software sets, hardware clears; a same-cycle write wins
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      slots <= '0;
      csm   <= '0;
    end else begin
      if (evt) begin
        slots.slot_result[cur_uf] <= rsp_i.result;
        slots.start_split_mask    <= ss_after;
        csm.complete_split_mask   <= cs_after;
      end
      if (wr_slots) slots <= isde_slots_t'(wdata_i);
      if (wr_csm) begin
        csm      <= isde_csplit_t'(wdata_i);
        csm.rsvd <= '0;
      end
    end
  end

  // Status: software write first, hardware events override it
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stat <= '0;
    end else begin
      if (wr_stat) begin
        stat       <= isde_status_t'(wdata_i);
        stat.rsvd0 <= '0;
        stat.rsvd1 <= 1'b0;
      end
      if (evt) begin
        if (rsp_i.stall || fatal) stat.halted <= 1'b1;
        if (rsp_i.result[RES_BABBLE]) stat.babble <= 1'b1;
        if (err) stat.xact_err <= 1'b1;
        if (err && !fatal) begin
          stat.retry <= 2'(stat.retry - RETRY_STEP);
        end
        if (good_data) begin
          stat.data_toggle <= !stat.data_toggle;
          stat.bytes_done  <= rsp_i.bytes;
        end
        // Phase flips to complete after an IN start split succeeds
        if (good && !cur_cs && ctrl.is_in) stat.split_phase <= 1'b1;
        if (finish) begin
          stat.active      <= 1'b0;
          stat.split_phase <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= RD_ZERO;
    end else if (rd_i) begin
      unique case (addr_i)
        REG_ROUTE:  rdata_o <= 32'(route);
        REG_SCHED:  rdata_o <= 32'(sched);
        REG_STATUS: rdata_o <= 32'(stat);
        REG_SLOTS:  rdata_o <= 32'(slots);
        REG_CSPLIT: rdata_o <= 32'(csm);
        REG_CTRL:   rdata_o <= 32'(ctrl);
        default:    rdata_o <= RD_ZERO;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  chk_ss_clear: assert property (
    evt && good && !cur_cs && !wr_slots |=>
      (slots.start_split_mask & $past(cur_bit)) == MASK_NONE)
    else $error("start-split bit not cleared");
  chk_frame_gate: assert property (
    (state == ST_IDLE) && uf_start_i && !due |=> !req_valid_o)
    else $error("request issued outside due frame");
  chk_run_clear: assert property (
    finish && !wr_stat && !wr_ctrl |=> !stat.active && !ctrl.valid)
    else $error("running or valid flag left set");
  chk_halt_set: assert property (
    evt && rsp_i.stall |=> stat.halted)
    else $error("halt not set on stall");
  chk_babble_set: assert property (
    evt && rsp_i.result[RES_BABBLE] |=> stat.babble)
    else $error("babble not reflected");
  chk_xerr_set: assert property (
    evt && err |=> stat.xact_err)
    else $error("transaction error not reflected");
  chk_toggle_flip: assert property (
    evt && good_data && !wr_stat |=>
      stat.data_toggle != $past(stat.data_toggle))
    else $error("toggle did not flip");
  chk_retry_dec: assert property (
    evt && err && !fatal && !wr_stat |=>
      stat.retry == 2'($past(stat.retry) - RETRY_STEP))
    else $error("retry count not decremented");
  chk_bytes_wb: assert property (
    evt && good_data && !wr_stat |=>
      stat.bytes_done == $past(rsp_i.bytes))
    else $error("byte count not written back");
  chk_req_fields: assert property (
    issue |=> req_valid_o && req_o.buffer_base == $past(sched.buffer_base)
      && req_o.hub_addr == $past(route.hub_addr))
    else $error("request fields wrong");
  chk_req_hold: assert property (
    req_valid_o && !rsp_valid_i |=> req_valid_o [*1])
    else $error("request dropped before answer");
  chk_every_frame: assert property (
    ctrl.interval_exp == EXP_MIN |-> due)
    else $error("exponent four not due every frame");

  cov_start_split: cover property (evt && good && !cur_cs);
  cov_complete_fin: cover property (evt && cur_cs && finish);
  cov_retry: cover property (evt && err && !fatal);
  cov_stall: cover property (evt && rsp_i.stall);

endmodule
`default_nettype wire

// File: sim/isde_engine_model.sv
// Behavioural transaction engine that answers split requests
`default_nettype none
module isde_engine_model
  import isde_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       nrst_i,
  input  wire logic       req_valid_i,
  input  wire logic [7:0] delay_i,
  input  wire isde_rsp_t  rsp_pat_i,
  output logic            rsp_valid_o,
  output isde_rsp_t       rsp_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] cnt;
  logic       done;

  // ---------------------------------------------------------------
  // Answer once per request after delay_i cycles
  // ---------------------------------------------------------------
  // Outside the answer cycle the response lines toggle, so stale data
  // never looks valid to the block.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt         <= 8'h00;
      done        <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_o       <= '0;
    end else begin
      rsp_valid_o <= 1'b0;
      if (!req_valid_i || done) begin
        rsp_o <= ~rsp_o;
        if (!req_valid_i) begin
          cnt  <= 8'h00;
          done <= 1'b0;
        end
      end else if (cnt >= delay_i) begin
        rsp_valid_o <= 1'b1;
        rsp_o       <= rsp_pat_i;
        done        <= 1'b1;
      end else begin
        cnt   <= cnt + 8'h01;
        rsp_o <= ~rsp_o;
      end
    end
  end
endmodule
`default_nettype wire

// File: sim/isde_exec_bench.sv
// Self-checking bench for the interrupt split descriptor executor
`default_nettype none
module isde_exec_bench
  import isde_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        nrst;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        uf_start;
  logic [2:0]  uframe;
  logic [10:0] frame;
  logic        req_valid;
  isde_req_t   req;
  logic        rsp_valid;
  isde_rsp_t   rsp;
  isde_rsp_t   rsp_pat;
  logic [7:0]  delay;
  int          fail_count;
  int          n_checks;

  isde_exec u_dut (
    .sys_clk_i   (clk),
    .nrst_i      (nrst),
    .addr_i      (addr),
    .wdata_i     (wdata),
    .wr_i        (wr),
    .rd_i        (rd),
    .rdata_o     (rdata),
    .uf_start_i  (uf_start),
    .uframe_i    (uframe),
    .frame_num_i (frame),
    .req_valid_o (req_valid),
    .req_o       (req),
    .rsp_valid_i (rsp_valid),
    .rsp_i       (rsp)
  );

  isde_engine_model u_engine (
    .sys_clk_i   (clk),
    .nrst_i      (nrst),
    .req_valid_i (req_valid),
    .delay_i     (delay),
    .rsp_pat_i   (rsp_pat),
    .rsp_valid_o (rsp_valid),
    .rsp_o       (rsp)
  );

  always #5 clk = ~clk;

  // ---------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] seen,
                     input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), {32'h0, rdata}, {32'h0, exp});
  endtask

  function automatic isde_req_t mk(input logic c, input logic i,
                                   input logic [2:0] u, input logic t,
                                   input logic [15:0] b);
    return '{c, i, u, 7'h55, 7'h2a, 2'h2, t, b};
  endfunction

  // Microframe start; a request is expected when go is set
  task automatic do_uf(input logic [2:0] u, input logic [10:0] f,
                       input logic go, input isde_req_t er,
                       input isde_rsp_t rp, input logic [7:0] dl);
    int   k;
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    uf_start <= 1'b1;
    uframe   <= u;
    frame    <= f;
    rsp_pat  <= rp;
    delay    <= dl;
    @(posedge clk);
    uf_start <= 1'b0;
    for (k = 0; k < (go ? 50 : 8) && !seen; k++) begin
      #1;
      seen = (req_valid === 1'b1);
      if (!seen) @(posedge clk);
    end
    chk("req_valid", {63'h0, seen}, {63'h0, go});
    if (go && !seen) stop_test();
    if (go) begin
      chk("req", {26'h0, req}, {26'h0, er});
      k = 0;
      while (req_valid === 1'b1 && k < 300) begin
        @(posedge clk);
        #1;
        k++;
      end
      chk("req_drop", {63'h0, req_valid}, 64'h0);
      if (k >= 300) stop_test();
    end
  endtask

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0; nrst = 1'b0; addr = 8'h00; wdata = 32'h0;
    wr = 1'b0; rd = 1'b0; uf_start = 1'b0; uframe = 3'h0;
    frame = 11'h0; rsp_pat = '0; delay = 8'h00;
    fail_count = 0; n_checks = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 7; i++) rd_reg(8'(i * 4), 32'h0);
    wr_reg(8'h18, 32'hffffffff);
    rd_reg(8'h18, 32'h0);
    wr_reg(REG_ROUTE, 32'hffffffff);
    rd_reg(REG_ROUTE, 32'hffff0000);
    wr_reg(REG_SCHED, 32'hffffffff);
    rd_reg(REG_SCHED, 32'h00ffffff);
    wr_reg(REG_STATUS, 32'hffffffff);
    rd_reg(REG_STATUS, 32'hfb800fff);
    wr_reg(REG_CTRL, 32'hffffffff);
    rd_reg(REG_CTRL, 32'h0000007f);
    wr_reg(REG_CTRL, 32'h0);
    wr_reg(REG_STATUS, 32'h0);
    $display("test 1 registers done");

    // IN: start split in uframe 0, complete split in uframe 2
    wr_reg(REG_ROUTE, 32'haaaa0000);
    wr_reg(REG_SCHED, 32'h00123400);
    wr_reg(REG_SLOTS, 32'h00000001);
    wr_reg(REG_CSPLIT, 32'h00000004);
    wr_reg(REG_STATUS, 32'h81800000);
    wr_reg(REG_CTRL, 32'h00000013);
    do_uf(3'h0, 11'h5, 1'b1, mk(0, 1, 0, 0, 16'h1234), '0, 8'h2);
    rd_reg(REG_STATUS, 32'h89800000);
    rd_reg(REG_SLOTS, 32'h0);
    do_uf(3'h1, 11'h5, 1'b0, '0, '0, 8'h0);
    do_uf(3'h2, 11'h5, 1'b1, mk(1, 1, 2, 0, 16'h1234),
          '{3'h1, 1'b0, 1'b0, 12'h0}, 8'h0);
    rd_reg(REG_STATUS, 32'h99000000);
    rd_reg(REG_SLOTS, 32'h00004000);
    rd_reg(REG_CSPLIT, 32'h00000004);
    do_uf(3'h2, 11'h6, 1'b1, mk(1, 1, 2, 0, 16'h1234),
          '{3'h0, 1'b0, 1'b1, 12'h040}, 8'h0);
    rd_reg(REG_STATUS, 32'h13000040);
    rd_reg(REG_CSPLIT, 32'h0);
    rd_reg(REG_CTRL, 32'h00000012);
    $display("test 2 in split done");

    // OUT, period of two frames, engine reports a stall
    wr_reg(REG_SCHED, 32'h00abcd08);
    wr_reg(REG_SLOTS, 32'h00000001);
    wr_reg(REG_STATUS, 32'h82000000);
    wr_reg(REG_CTRL, 32'h00000015);
    do_uf(3'h0, 11'h2, 1'b0, '0, '0, 8'h0);
    do_uf(3'h0, 11'h3, 1'b1, mk(0, 0, 0, 1, 16'habcd),
          '{3'h4, 1'b1, 1'b0, 12'h0}, 8'h1);
    rd_reg(REG_STATUS, 32'h42000000);
    rd_reg(REG_SLOTS, 32'h00000401);
    rd_reg(REG_CTRL, 32'h00000014);
    do_uf(3'h0, 11'h3, 1'b0, '0, '0, 8'h0);
    $display("test 3 out stall done");

    // OUT with no retries left, slow engine, error and babble
    wr_reg(REG_SCHED, 32'h00abcd00);
    wr_reg(REG_SLOTS, 32'h00000002);
    wr_reg(REG_STATUS, 32'h80000000);
    wr_reg(REG_CTRL, 32'h00000011);
    do_uf(3'h1, 11'h7, 1'b1, mk(0, 0, 1, 0, 16'habcd),
          '{3'h3, 1'b0, 1'b0, 12'h0}, 8'd20);
    rd_reg(REG_STATUS, 32'h70000000);
    rd_reg(REG_SLOTS, 32'h00001802);
    $display("test 4 retry exhaustion done");
    stop_test();
  end
endmodule
`default_nettype wire
